// [pmcg_checker.sv]
// concurrent checks on the ports of pmcg_top
// assumes it is bound to pmcg_top and sees only that module's ports
`timescale 1ns/1ps
module pmcg_checker (
   input wire logic core_clk, // core clock
   input wire logic sys_rst, // synchronous reset
   input wire logic clk_en, // run enable
   input wire logic [7:0] reg_addr, // byte address
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire logic [31:0] reg_rdata, // read data
   input wire logic main_osc_en, // oscillator enable
   input wire logic master_clk_tick, // master tick
   input wire logic [27:0] periph_clk_tick, // peripheral ticks
   input wire logic [3:0] ahb_periph_clk_tick, // ahb ticks
   input wire logic usb_host_clk, // usb host level
   input wire logic [3:0] prog_clk_out // programmable outputs
);
   logic [31:0] per_en_ff;
   logic [11:0] sys_en_ff;
   wire wr_go = reg_wr && clk_en;
   wire [31:0] nxt_per_en = (wr_go && reg_addr == 8'h10) ? (per_en_ff | reg_wdata) :
      (wr_go && reg_addr == 8'h14) ? (per_en_ff & ~reg_wdata) : per_en_ff;
   wire [11:0] nxt_sys_en = (wr_go && reg_addr == 8'h00) ? (sys_en_ff | reg_wdata[11:0]) :
      (wr_go && reg_addr == 8'h04) ? (sys_en_ff & ~reg_wdata[11:0]) : sys_en_ff;
   always_ff @(posedge core_clk) begin
      per_en_ff <= sys_rst ? 32'h0 : nxt_per_en;
      sys_en_ff <= sys_rst ? 12'h0 : nxt_sys_en;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence s_cfg_wr(a);
      reg_wr && clk_en && reg_addr == a;
   endsequence
   sequence s_stat_rd;
      reg_rd && clk_en && reg_addr == 8'h68;
   endsequence
   // gated outputs may lag their enable bit by one cycle
   chk_unmapped_zero: assert property (
      reg_rd && clk_en && reg_addr == 8'h5C |=> reg_rdata == 32'h0)
      else $error("unmapped read");
   chk_per_gated: assert property (
      (periph_clk_tick & ~per_en_ff[27:0] & ~$past(per_en_ff[27:0])) == 28'h0)
      else $error("periph tick off");
   chk_ahb_gated: assert property (
      (ahb_periph_clk_tick & ~per_en_ff[31:28] & ~$past(per_en_ff[31:28])) == 4'h0)
      else $error("ahb tick off");
   chk_host_gated: assert property (
      usb_host_clk |-> sys_en_ff[6] || $past(sys_en_ff[6]))
      else $error("host clk off");
   chk_prog_gated: assert property (
      (prog_clk_out & ~sys_en_ff[11:8] & ~$past(sys_en_ff[11:8])) == 4'h0)
      else $error("prog out off");
   chk_ready_clears: assert property (
      s_cfg_wr(8'h30) ##1 s_stat_rd |=> !reg_rdata[3])
      else $error("master ready set");
   chk_prog_rdy_clr: assert property (
      s_cfg_wr(8'h40) ##1 s_stat_rd |=> !reg_rdata[8])
      else $error("prog ready set");
   chk_osc_follows: assert property (
      s_cfg_wr(8'h20) |=> main_osc_en == $past(reg_wdata[0]))
      else $error("osc enable");
   chk_per_status: assert property (
      reg_rd && clk_en && reg_addr == 8'h18 |=> reg_rdata == $past(per_en_ff))
      else $error("periph status");
   chk_tick_single: assert property (
      master_clk_tick |=> !master_clk_tick)
      else $error("long master tick");
endmodule

bind pmcg_top pmcg_checker u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .main_osc_en(main_osc_en), .master_clk_tick(master_clk_tick),
   .periph_clk_tick(periph_clk_tick), .ahb_periph_clk_tick(ahb_periph_clk_tick),
   .usb_host_clk(usb_host_clk), .prog_clk_out(prog_clk_out));

// [pmcg_defs.svh]
// offsets, field positions, reset values and counts of the clock gating block
// assumes byte addresses on an 8-bit register port, one 32-bit word per register
`ifndef PMCG_DEFS_SVH
`define PMCG_DEFS_SVH

`define PMCG_ADDR_W 8
`define PMCG_SYS_CLK_EN_OFS 8'h00
`define PMCG_SYS_CLK_DIS_OFS 8'h04
`define PMCG_SYS_CLK_STAT_OFS 8'h08
`define PMCG_PER_CLK_EN_OFS 8'h10
`define PMCG_PER_CLK_DIS_OFS 8'h14
`define PMCG_PER_CLK_STAT_OFS 8'h18
`define PMCG_MAIN_OSC_OFS 8'h20
`define PMCG_PLL_B_CFG_OFS 8'h2C
`define PMCG_MASTER_CFG_OFS 8'h30
`define PMCG_PROG_CFG0_OFS 8'h40
`define PMCG_STATUS_OFS 8'h68

// system clock register bit positions
`define PMCG_SC_CPU_BIT 0
`define PMCG_SC_HOST_BIT 6
`define PMCG_SC_DEV_BIT 7
`define PMCG_SC_PROG_LSB 8

// peripheral ids below this bit, ahb clocks from it upward
`define PMCG_NUM_PERIPH 28
`define PMCG_AHB_LSB 28
`define PMCG_NUM_AHB 4
`define PMCG_NUM_PROG 4

// main oscillator register fields
`define PMCG_OSC_EN_BIT 0
`define PMCG_OSC_CNT_LSB 8
`define PMCG_OSC_CNT_MSB 15
// usb divider field of the pll b register
`define PMCG_USB_DIV_LSB 28
`define PMCG_USB_DIV_MSB 29

// status register bit positions
`define PMCG_SR_OSC_BIT 0
`define PMCG_SR_LOCK_A_BIT 1
`define PMCG_SR_LOCK_B_BIT 2
`define PMCG_SR_MRDY_BIT 3
`define PMCG_SR_PROG_LSB 8

// reset values: slow clock undivided, usb divider by 1
`define PMCG_CFG_RST 5'h00
`define PMCG_USB_DIV_RST 2'h0
`define PMCG_SYS_EN_RST 1'h1

// oscillator count steps once per this many slow clock rises
`define PMCG_OSC_SLOW_DIV 4'h8
`define PMCG_OSC_DIV_LAST 3'h7

`endif

// [pmcg_far_model.sv]
// far side: source clocks, pll locks and the core handshake
// assumes a 4 ns core_clk; sources run free, edges kept 1 ns off the core edges
`timescale 1ns/1ps
module pmcg_far_model (
   input wire logic core_clk, // core clock
   input wire logic instr_hold, // keep an instruction in flight
   input wire logic irq_req, // raise an enabled interrupt
   output logic slow_clk, // 20 core cycles
   output logic main_clk, // 10 core cycles
   output logic pll_a_clk, // 6 core cycles
   output logic pll_b_clk, // 8 core cycles
   output logic pll_a_lock, // pll a locked
   output logic pll_b_lock, // pll b locked
   output logic cpu_instr_done, // no instruction in flight
   output logic cpu_wake_irq // wake interrupt
);
   initial begin
      {slow_clk, main_clk, pll_a_clk, pll_b_clk, pll_a_lock, pll_b_lock} = 6'h0;
      #1;
      fork
         forever #40 slow_clk = ~slow_clk;
         forever #20 main_clk = ~main_clk;
         forever #12 pll_a_clk = ~pll_a_clk;
         forever #16 pll_b_clk = ~pll_b_clk; // usb source only from pll b
         #300 {pll_a_lock, pll_b_lock} = 2'h3; // lock reported once stable
      join
   end
   // done one cycle after the hold drops
   always_ff @(posedge core_clk) cpu_instr_done <= !instr_hold;
   assign cpu_wake_irq = irq_req;
endmodule

// [pmcg_pkg.sv]
// types shared by the clock gating block
// assumes pmcg_defs.svh carries the numeric constants
package pmcg_pkg;

   // source encoding of the clock-source fields
   typedef enum logic [1:0] {
      PMCG_SRC_SLOW = 2'h0,
      PMCG_SRC_MAIN = 2'h1,
      PMCG_SRC_PLL_A = 2'h2,
      PMCG_SRC_PLL_B = 2'h3
   } pmcg_src_type;

   // a divider configuration: prescale_sel in [4:2], clk_src_sel in [1:0]
   typedef struct packed {
      logic [2:0] prescale_sel;
      logic [1:0] clk_src_sel;
   } pmcg_clk_cfg_type;

   // processor clock controller, one-hot
   typedef enum logic [2:0] {
      PMCG_CPU_RUN = 3'h1,
      PMCG_CPU_DRAIN = 3'h2,
      PMCG_CPU_IDLE = 3'h4
   } pmcg_cpu_state_type;

endpackage

// [pmcg_top.sv]
// power management clock controller: master clock selection and prescale,
// processor idle gating, peripheral, ahb and usb clock gating, programmable clock outputs
// assumes source clocks arrive on pins and are far slower than core_clk; derived clocks
// are rebuilt as levels on core_clk and the cpu, peripheral and ahb clocks are given as one-cycle enables
// Operation
// - master clock source from clk_src_sel, divided by power of two 1..64
// - each master config write clears ready until the new clock applies
// - processor bit in disable register stops cpu clock; status shows it running
// - cpu clock runs after reset; enabled interrupt or reset restarts it
// - current instruction finishes before stopping; other bus masters unaffected
// - usb clock always from pll b, divided by 1, 2 or 4 per usb_clk_divider for 48 MHz
// - host-port bit starts or stops usb host clock; status shows it
// - device-port bit starts or stops usb device clock; status shows it
// - enable, disable and status bits gate each peripheral clock
// - peripheral clock stops at once when disabled; all disabled after reset
// - peripheral clock bit position equals the peripheral identifier
// - four ahb clocks gated through peripheral registers, off after reset
// - re-enabled ahb clock lets the peripheral resume its held state
// - four programmable clock outputs, each with its own config register
// - programmable output source from four clocks, divided by power of two 1..64
// - system enable and disable bits switch outputs; status shows active ones
// - per output ready flag, cleared while a configuration change is pending
// - main oscillator enable bit starts it; startup count in same register
// - stable flag clears, count steps at slow clock by eight, sets at zero
// - unlocked pll falls master back to slow or main; ready low until relock
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "pmcg_defs.svh"

module pmcg_top
   import pmcg_pkg::*;
(
   input wire logic core_clk, // 250 MHz core clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic clk_en, // freezes all state while low
   input wire logic [7:0] reg_addr, // register byte address
   input wire logic [31:0] reg_wdata, // register write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [31:0] reg_rdata, // read data, cycle after the strobe
   input wire logic slow_clk, // slow clock pin
   input wire logic main_clk, // main oscillator clock pin
   input wire logic pll_a_clk, // pll a output pin
   input wire logic pll_b_clk, // pll b output pin
   input wire logic pll_a_lock, // pll a locked
   input wire logic pll_b_lock, // pll b locked
   input wire logic cpu_instr_done, // core has no instruction in flight
   input wire logic cpu_wake_irq, // enabled fast or normal interrupt pending
   output logic main_osc_en, // main oscillator enable
   output logic master_clk, // rebuilt master clock level
   output logic master_clk_tick, // master clock rising-edge enable
   output logic cpu_clk_tick, // processor clock enable
   output logic [27:0] periph_clk_tick, // per-peripheral clock enables
   output logic [3:0] ahb_periph_clk_tick, // ahb peripheral clock enables
   output logic usb_host_clk, // usb host clock level
   output logic usb_dev_clk, // usb device clock level
   output logic [3:0] prog_clk_out // programmable clock pins
);

   localparam int NDIV = 5;

   // pins: slow, main, pll a, pll b, lock a, lock b
   logic [5:0] sync1_ff;
   logic [5:0] sync2_ff;
   logic [3:0] prev_ff;
   logic [3:0] src_lvl;
   logic [3:0] src_rise;
   logic lock_a;
   logic lock_b;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sync1_ff <= 6'h00;
         sync2_ff <= 6'h00;
         prev_ff <= 4'h0;
      end else if (clk_en) begin
         sync1_ff <= {pll_b_lock, pll_a_lock, pll_b_clk, pll_a_clk, main_clk, slow_clk};
         sync2_ff <= sync1_ff;
         prev_ff <= sync2_ff[3:0];
      end
   end

   assign src_lvl = sync2_ff[3:0];
   assign src_rise = sync2_ff[3:0] & ~prev_ff;
   assign lock_a = sync2_ff[4];
   assign lock_b = sync2_ff[5];

   // address decode
   wire wr_sys_en = reg_wr && (reg_addr == `PMCG_SYS_CLK_EN_OFS);
   wire wr_sys_dis = reg_wr && (reg_addr == `PMCG_SYS_CLK_DIS_OFS);
   wire wr_per_en = reg_wr && (reg_addr == `PMCG_PER_CLK_EN_OFS);
   wire wr_per_dis = reg_wr && (reg_addr == `PMCG_PER_CLK_DIS_OFS);
   wire wr_osc = reg_wr && (reg_addr == `PMCG_MAIN_OSC_OFS);
   wire wr_pll_b = reg_wr && (reg_addr == `PMCG_PLL_B_CFG_OFS);
   wire wr_master = reg_wr && (reg_addr == `PMCG_MASTER_CFG_OFS);
   wire [3:0] prog_sel = reg_addr[3:0];
   wire wr_prog_any = reg_wr && (reg_addr[7:4] == `PMCG_PROG_CFG0_OFS >> 4) &&
                      (prog_sel[1:0] == 2'h0);

   // system clocks: cpu, usb host, usb device, programmable outputs
   logic host_en_ff;
   logic dev_en_ff;
   logic [3:0] prog_en_ff;
   wire [3:0] sys_en_prog = reg_wdata[`PMCG_SC_PROG_LSB +: 4];

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         host_en_ff <= 1'h0;
         dev_en_ff <= 1'h0;
         prog_en_ff <= 4'h0;
      end else if (clk_en) begin
         // only bits written 1 act
         if (wr_sys_en) begin
            host_en_ff <= host_en_ff | reg_wdata[`PMCG_SC_HOST_BIT];
            dev_en_ff <= dev_en_ff | reg_wdata[`PMCG_SC_DEV_BIT];
            prog_en_ff <= prog_en_ff | sys_en_prog;
         end else if (wr_sys_dis) begin
            host_en_ff <= host_en_ff & ~reg_wdata[`PMCG_SC_HOST_BIT];
            dev_en_ff <= dev_en_ff & ~reg_wdata[`PMCG_SC_DEV_BIT];
            prog_en_ff <= prog_en_ff & ~sys_en_prog;
         end
      end
   end

   // processor idle mode
   pmcg_cpu_state_type cpu_state_ff;
   pmcg_cpu_state_type nxt_cpu_state;
   wire cpu_stop_req = wr_sys_dis && reg_wdata[`PMCG_SC_CPU_BIT];
   wire cpu_run_req = wr_sys_en && reg_wdata[`PMCG_SC_CPU_BIT];

   always_comb begin
      nxt_cpu_state = cpu_state_ff;
      case (cpu_state_ff)
         PMCG_CPU_RUN: begin
            if (cpu_stop_req) begin
               nxt_cpu_state = PMCG_CPU_DRAIN;
            end
         end
         PMCG_CPU_DRAIN: begin
            // the core keeps its clock until the instruction in flight retires
            if (cpu_wake_irq || cpu_run_req) begin
               nxt_cpu_state = PMCG_CPU_RUN;
            end else if (cpu_instr_done) begin
               nxt_cpu_state = PMCG_CPU_IDLE;
            end
         end
         PMCG_CPU_IDLE: begin
            if (cpu_wake_irq || cpu_run_req) begin
               nxt_cpu_state = PMCG_CPU_RUN;
            end
         end
         default: begin
            nxt_cpu_state = PMCG_CPU_RUN;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cpu_state_ff <= PMCG_CPU_RUN;
      end else if (clk_en) begin
         cpu_state_ff <= nxt_cpu_state;
      end
   end

   wire cpu_running = (cpu_state_ff != PMCG_CPU_IDLE);

   // peripheral and ahb clock gates, all off after reset
   logic [31:0] per_en_ff;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         per_en_ff <= 32'h0;
      end else if (clk_en) begin
         // bit n gates the peripheral with identifier n
         if (wr_per_en) begin
            per_en_ff <= per_en_ff | reg_wdata;
         end else if (wr_per_dis) begin
            per_en_ff <= per_en_ff & ~reg_wdata;
         end
      end
   end

   // main oscillator startup counter
   logic osc_en_ff;
   logic osc_stable_ff;
   logic [7:0] osc_cnt_ff;
   logic [2:0] osc_div_ff;
   wire osc_step = src_rise[PMCG_SRC_SLOW] && (osc_div_ff == `PMCG_OSC_DIV_LAST);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         osc_en_ff <= 1'h0;
         osc_stable_ff <= 1'h0;
         osc_cnt_ff <= 8'h00;
         osc_div_ff <= 3'h0;
      end else if (clk_en) begin
         if (wr_osc) begin
            osc_en_ff <= reg_wdata[`PMCG_OSC_EN_BIT];
            osc_cnt_ff <= reg_wdata[`PMCG_OSC_CNT_MSB:`PMCG_OSC_CNT_LSB];
            osc_div_ff <= 3'h0;
            osc_stable_ff <= 1'h0;
         end else if (osc_en_ff && !osc_stable_ff) begin
            if (osc_cnt_ff == 8'h00) begin
               osc_stable_ff <= 1'h1;
            end else if (src_rise[PMCG_SRC_SLOW]) begin
               osc_div_ff <= osc_div_ff + 3'h1;
               if (osc_step) begin
                  osc_cnt_ff <= osc_cnt_ff - 8'h01;
               end
            end
         end
      end
   end

   // usb clock from pll b only
   logic [1:0] usb_div_ff;
   logic [1:0] usb_cnt_ff;
   logic usb_lvl_ff;
   logic host_clk_ff;
   logic dev_clk_ff;
   wire nxt_usb_lvl = (usb_div_ff == 2'h0) ? src_lvl[PMCG_SRC_PLL_B] :
                      (usb_div_ff == 2'h1) ? usb_cnt_ff[0] : usb_cnt_ff[1];

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         usb_div_ff <= `PMCG_USB_DIV_RST;
         usb_cnt_ff <= 2'h0;
         usb_lvl_ff <= 1'h0;
         host_clk_ff <= 1'h0;
         dev_clk_ff <= 1'h0;
      end else if (clk_en) begin
         if (wr_pll_b) begin
            usb_div_ff <= reg_wdata[`PMCG_USB_DIV_MSB:`PMCG_USB_DIV_LSB];
         end
         if (src_rise[PMCG_SRC_PLL_B]) begin
            usb_cnt_ff <= usb_cnt_ff + 2'h1;
         end
         usb_lvl_ff <= nxt_usb_lvl;
         // enabling before pll b locks would pass an unstable clock
         host_clk_ff <= host_en_ff & usb_lvl_ff;
         dev_clk_ff <= dev_en_ff & usb_lvl_ff;
      end
   end

   // dividers: index 0 is the master clock, 1..4 the programmable outputs
   pmcg_clk_cfg_type req_ff [NDIV];
   pmcg_clk_cfg_type cfg_ff [NDIV];
   logic [NDIV-1:0] pend_ff;
   logic [NDIV-1:0] lvl_ff;
   logic [NDIV-1:0] nxt_lvl;
   logic [NDIV-1:0] div_wr;
   logic [1:0] eff_src [NDIV];

   // an unlocked pll drops the master clock back to a safe source
   wire master_fallback = ((cfg_ff[0].clk_src_sel == PMCG_SRC_PLL_A) && !lock_a) ||
                          ((cfg_ff[0].clk_src_sel == PMCG_SRC_PLL_B) && !lock_b);
   assign eff_src[0] = !master_fallback ? cfg_ff[0].clk_src_sel :
                       (cfg_ff[0].clk_src_sel == PMCG_SRC_PLL_A) ? PMCG_SRC_SLOW :
                       PMCG_SRC_MAIN;
   assign div_wr[0] = wr_master;

   genvar g;
   generate
      for (g = 0; g < NDIV; g = g + 1) begin : gen_div
         logic [5:0] cnt_ff;
         logic [2:0] top_bit;
         // an out-of-range prescale code divides by 64
         assign top_bit = (cfg_ff[g].prescale_sel > 3'h6) ? 3'h5 :
                          cfg_ff[g].prescale_sel - 3'h1;
         if (g > 0) begin : gen_prog
            assign eff_src[g] = cfg_ff[g].clk_src_sel;
            assign div_wr[g] = wr_prog_any && (prog_sel[3:2] == 2'(g - 1));
         end
         assign nxt_lvl[g] = (cfg_ff[g].prescale_sel == 3'h0) ? src_lvl[eff_src[g]] :
                             cnt_ff[top_bit];

         // a new setting takes over only while the output sits low and the counter
         // restarts from zero, so no high phase is ever cut short
         wire apply = pend_ff[g] && !lvl_ff[g];

         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               req_ff[g] <= `PMCG_CFG_RST;
               cfg_ff[g] <= `PMCG_CFG_RST;
               pend_ff[g] <= 1'h0;
               cnt_ff <= 6'h00;
               lvl_ff[g] <= 1'h0;
            end else if (clk_en) begin
               if (div_wr[g]) begin
                  req_ff[g] <= reg_wdata[4:0];
               end
               if (apply) begin
                  cfg_ff[g] <= req_ff[g];
                  cnt_ff <= 6'h00;
                  lvl_ff[g] <= 1'h0;
               end else begin
                  if (src_rise[eff_src[g]]) begin
                     cnt_ff <= cnt_ff + 6'h01;
                  end
                  lvl_ff[g] <= nxt_lvl[g];
               end
               // a write in the apply cycle keeps the change pending
               pend_ff[g] <= div_wr[g] | (pend_ff[g] & ~apply);
            end
         end
      end
   endgenerate

   wire master_ready = !pend_ff[0] && !master_fallback;
   wire [3:0] prog_ready = ~pend_ff[4:1];
   wire master_rise = nxt_lvl[0] && !lvl_ff[0];

   // gated clock enables and pins, all from flops
   logic master_tick_ff;
   logic cpu_tick_ff;
   logic [31:0] per_tick_ff;
   logic [3:0] prog_out_ff;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         master_tick_ff <= 1'h0;
         cpu_tick_ff <= 1'h0;
         per_tick_ff <= 32'h0;
         prog_out_ff <= 4'h0;
      end else if (clk_en) begin
         master_tick_ff <= master_rise;
         // other bus masters keep the master clock while the cpu idles
         cpu_tick_ff <= master_rise && cpu_running;
         // a cleared bit stops its enable on the very next edge
         per_tick_ff <= {32{master_rise}} & per_en_ff;
         prog_out_ff <= prog_en_ff & lvl_ff[4:1];
      end
   end

   // read side; status registers ignore writes
   wire [31:0] sys_stat = {20'h0, prog_en_ff, dev_en_ff, host_en_ff, 5'h00,
                           cpu_running};
   wire [31:0] osc_rd = {16'h0, osc_cnt_ff, 7'h00, osc_en_ff};
   wire [31:0] pll_b_rd = {2'h0, usb_div_ff, 28'h0};
   wire [31:0] status_rd = {20'h0, prog_ready, 4'h0, master_ready, lock_b, lock_a,
                            osc_stable_ff};
   wire [31:0] prog_rd = {27'h0, req_ff[1 + 32'(prog_sel[3:2])]};
   wire [31:0] rd_mux =
      (reg_addr == `PMCG_SYS_CLK_STAT_OFS) ? sys_stat :
      (reg_addr == `PMCG_PER_CLK_STAT_OFS) ? per_en_ff :
      (reg_addr == `PMCG_MAIN_OSC_OFS) ? osc_rd :
      (reg_addr == `PMCG_PLL_B_CFG_OFS) ? pll_b_rd :
      (reg_addr == `PMCG_MASTER_CFG_OFS) ? {27'h0, req_ff[0]} :
      (reg_addr == `PMCG_STATUS_OFS) ? status_rd :
      (reg_addr[7:4] == `PMCG_PROG_CFG0_OFS >> 4 && prog_sel[1:0] == 2'h0) ? prog_rd :
      32'h0;

   logic [31:0] rdata_ff;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rdata_ff <= 32'h0;
      end else if (clk_en) begin
         // data stands only in the cycle after the strobe
         rdata_ff <= reg_rd ? rd_mux : 32'h0;
      end
   end

   assign reg_rdata = rdata_ff;
   assign main_osc_en = osc_en_ff;
   assign master_clk = lvl_ff[0];
   assign master_clk_tick = master_tick_ff;
   assign cpu_clk_tick = cpu_tick_ff;
   assign periph_clk_tick = per_tick_ff[`PMCG_NUM_PERIPH-1:0];
   assign ahb_periph_clk_tick = per_tick_ff[`PMCG_AHB_LSB +: `PMCG_NUM_AHB];
   assign usb_host_clk = host_clk_ff;
   assign usb_dev_clk = dev_clk_ff;
   assign prog_clk_out = prog_out_ff;

endmodule

// [power_management_clock_gating_tb.sv]
// self-checking bench for pmcg_top
// assumes pmcg_far_model drives the source pins and the core handshake
`timescale 1ns/1ps
module power_management_clock_gating_tb;
   typedef struct packed {
      logic [7:0] wa;
      logic [31:0] wd;
      logic [7:0] ra;
      logic [31:0] ex;
   } pmcg_row_type;
   typedef struct packed {
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] m;
      int p;
      int g;
   } pmcg_clk_row_type;
   logic core_clk, sys_rst, clk_en, reg_wr, reg_rd, instr_hold, irq_req;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, v;
   logic slow_clk, main_clk, pll_a_clk, pll_b_clk, pll_a_lock, pll_b_lock;
   logic cpu_instr_done, cpu_wake_irq, main_osc_en, master_clk, master_clk_tick;
   logic cpu_clk_tick, usb_host_clk, usb_dev_clk;
   logic [27:0] periph_clk_tick;
   logic [3:0] ahb_periph_clk_tick, prog_clk_out;
   wire [2:0] probe = {usb_host_clk, prog_clk_out[0], master_clk_tick};
   int err_count, comparisons, n;
   pmcg_row_type rows [12] = '{
      {8'h10, 32'h5, 8'h18, 32'h5},
      {8'h14, 32'h1, 8'h18, 32'h4},
      {8'h10, 32'hF000_0000, 8'h18, 32'hF000_0004},
      {8'h14, 32'h3000_0000, 8'h18, 32'hC000_0004},
      {8'h00, 32'hF00, 8'h08, 32'hF01},
      {8'h04, 32'h500, 8'h08, 32'hA01},
      {8'h00, 32'hC0, 8'h08, 32'hAC1},
      {8'h04, 32'h80, 8'h08, 32'hA41},
      {8'h08, 32'hFFFF_FFFF, 8'h08, 32'hA41},
      {8'h40, 32'h1D, 8'h40, 32'h1D},
      {8'h4C, 32'h2, 8'h4C, 32'h2},
      {8'h5C, 32'hFFFF, 8'h5C, 32'h0}};
   pmcg_clk_row_type crows [6] = '{
      '{8'h30, 32'h09, 32'h8, 0, 40}, // main by 4
      '{8'h30, 32'h1D, 32'h8, 0, 640}, // main by 64
      '{8'h40, 32'h00, 32'h100, 1, 20}, // slow by 1
      '{8'h40, 32'h1E, 32'h100, 1, 384}, // pll a by 64
      '{8'h40, 32'h03, 32'h100, 1, 8}, // pll b by 1
      '{8'h2C, 32'h1000_0000, 32'h0, 2, 16}}; // pll b halved

   pmcg_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .slow_clk(slow_clk), .main_clk(main_clk), .pll_a_clk(pll_a_clk), .pll_b_clk(pll_b_clk),
      .pll_a_lock(pll_a_lock), .pll_b_lock(pll_b_lock), .cpu_instr_done(cpu_instr_done),
      .cpu_wake_irq(cpu_wake_irq), .main_osc_en(main_osc_en), .master_clk(master_clk),
      .master_clk_tick(master_clk_tick), .cpu_clk_tick(cpu_clk_tick),
      .periph_clk_tick(periph_clk_tick), .ahb_periph_clk_tick(ahb_periph_clk_tick),
      .usb_host_clk(usb_host_clk), .usb_dev_clk(usb_dev_clk), .prog_clk_out(prog_clk_out));
   pmcg_far_model far (.core_clk(core_clk), .instr_hold(instr_hold), .irq_req(irq_req),
      .slow_clk(slow_clk), .main_clk(main_clk), .pll_a_clk(pll_a_clk), .pll_b_clk(pll_b_clk),
      .pll_a_lock(pll_a_lock), .pll_b_lock(pll_b_lock), .cpu_instr_done(cpu_instr_done),
      .cpu_wake_irq(cpu_wake_irq));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // bus tasks start and end just after a rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge core_clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1 d = reg_rdata;
      @(posedge core_clk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
         input string nm);
      logic [31:0] d;
      rd(a, d);
      chk(nm, e, d & m);
   endtask
   // cycles between two rising edges of a probe line
   task automatic gap(input int i, output int c);
      int k;
      int f;
      logic p;
      f = -1;
      c = 0;
      p = 1'h1;
      for (k = 0; k < 1500 && c == 0; k++) begin
         @(posedge core_clk);
         #1;
         if (probe[i] && !p && f >= 0) c = k - f;
         if (probe[i] && !p && f < 0) f = k;
         p = probe[i];
      end
   endtask
   task automatic ticks(output int c);
      c = 0;
      repeat (60) begin
         @(posedge core_clk);
         #1 c += cpu_clk_tick;
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      core_clk = 1'h0;
      forever #2 core_clk = ~core_clk;
   end
   initial begin
      #100000;
      err_count++;
      print_verdict();
   end
   initial begin
      {sys_rst, clk_en, reg_wr, reg_rd, instr_hold, irq_req} = 6'h30;
      {reg_addr, reg_wdata, err_count, comparisons} = 0;
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'h0;
      repeat (80) @(posedge core_clk);
      rc(8'h68, 32'h6, 32'h6, "pll locks");
      foreach (rows[i]) begin
         wr(rows[i].wa, rows[i].wd);
         rd(rows[i].ra, v);
         chk("register row", rows[i].ex, v);
      end
      foreach (crows[i]) begin
         wr(8'h04, 32'h100); // programmable output 0 off while reconfigured
         @(posedge core_clk);
         wr(crows[i].a, crows[i].d);
         rd(8'h68, v);
         chk("ready clear", 32'h0, v & crows[i].m);
         for (n = 0; n < 400 && (v & crows[i].m) != crows[i].m; n++) rd(8'h68, v);
         chk("ready set", crows[i].m, v & crows[i].m);
         wr(8'h00, 32'h100);
         gap(crows[i].p, n);
         chk("clock gap", crows[i].g, n);
      end
      sys_rst <= 1'h1;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'h0;
      @(posedge core_clk);
      rc(8'h08, 32'hFFF, 32'h001, "sys status");
      rc(8'h18, 32'hFFFF_FFFF, 32'h0, "periph status");
      rc(8'h68, 32'hF09, 32'hF08, "power status");
      chk("gated ticks", 32'h0, {periph_clk_tick, ahb_periph_clk_tick});
      instr_hold <= 1'h1;
      wr(8'h04, 32'h1);
      ticks(n);
      chk("ticks draining", 32'h3, n);
      instr_hold <= 1'h0;
      repeat (4) @(posedge core_clk);
      ticks(n);
      chk("ticks idle", 32'h0, n);
      rc(8'h08, 32'h1, 32'h0, "cpu status");
      irq_req <= 1'h1;
      repeat (4) @(posedge core_clk);
      irq_req <= 1'h0;
      ticks(n);
      chk("ticks woken", 32'h3, n);
      wr(8'h20, 32'h0201);
      #1 chk("osc enable", 32'h1, main_osc_en);
      repeat (278) @(posedge core_clk);
      rc(8'h68, 32'h1, 32'h0, "osc pending");
      repeat (60) @(posedge core_clk);
      rc(8'h68, 32'h1, 32'h1, "osc stable");
      wr(8'h20, 32'h0);
      print_verdict();
   end
endmodule
